// *** src/host_port_pkg.sv ***
// constants shared by both ends of the parallel host port
// ****************************************************************
// ****************************************************************
package host_port_pkg;
   // ****************************************************************
   // modes and map
   // ****************************************************************
   localparam logic [2:0]  MODE_STROBED     = 3'h4;
   localparam logic [2:0]  MODE_SPLIT       = 3'h3;
   localparam logic [2:0]  MODE_RESET       = 3'h0;
   localparam logic [6:0]  MODE_REG_ADDR    = 7'h7f;
   localparam int unsigned MODE_LSB         = 0;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_NS           = 20;
   localparam int unsigned WR_BUSY_MAX_NS   = 182;
   localparam int unsigned WR_GAP_MIN_NS    = 160;
   localparam int unsigned RD_GAP_MIN_NS    = 15;
   localparam int unsigned SYNC_STAGES      = 2;
   localparam int unsigned WR_BUSY_CYC      = (WR_BUSY_MAX_NS / CLK_NS) > 0 ? WR_BUSY_MAX_NS / CLK_NS : 1;
   localparam int unsigned WR_GAP_CYC       = (WR_GAP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RD_GAP_CYC       = (RD_GAP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_W            = 5;
endpackage : host_port_pkg

// *** src/host_port_if.sv ***
// pin bundle between host and device ends
`timescale 1ns/100ps
`default_nettype none
interface host_port_if #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
);
   logic              chip_select_n;
   logic              write_strobe_n;
   logic              read_strobe_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] host_data;
   logic              host_data_oe_n;
   logic [DATA_W-1:0] dev_data;
   logic              dev_data_oe_n;
   logic              dev_ack;
   logic              dev_ack_oe_n;
   logic [DATA_W-1:0] data_bus;
   logic              transfer_ack;

   // wire levels, pull-up when nobody drives
   assign data_bus     = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : '1);
   assign transfer_ack = !dev_ack_oe_n ? dev_ack : 1'b1;

   modport dev (
      input  chip_select_n, write_strobe_n, read_strobe_n, addr, data_bus,
      output dev_data, dev_data_oe_n, dev_ack, dev_ack_oe_n
   );
   modport host (
      input  data_bus, transfer_ack,
      output chip_select_n, write_strobe_n, read_strobe_n, addr, host_data, host_data_oe_n
   );
endinterface : host_port_if
`default_nettype wire

// *** src/host_port_dev.sv ***
// device end of the parallel host port
`timescale 1ns/100ps
`default_nettype none
module host_port_dev #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // pins
   host_port_if.dev               pins,
   input  wire logic [2:0]        host_mode_select,
   // register file side
   output logic                   reg_rd,
   output logic                   reg_wr,
   output logic [ADDR_W-1:0]      reg_addr,
   output logic [DATA_W-1:0]      reg_wdata,
   input  wire logic [DATA_W-1:0] reg_rdata,
   // status
   output logic [2:0]             mode
);
   // ****************************************************************
   // checks
   // ****************************************************************
   if (ADDR_W != 7 || DATA_W < 3) begin : g_bad
      $error("host_port_dev: ADDR_W must be 7 and DATA_W at least 3");
   end

   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_FETCH = 4'b0010,
      S_HOLD  = 4'b0100,
      S_WCAP  = 4'b1000
   } dev_state_e;

   localparam int SW = 3 + ADDR_W + DATA_W;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic          cs_s;
   logic          wr_s;
   logic          rd_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;

   assign pin_raw = {pins.chip_select_n, pins.write_strobe_n, pins.read_strobe_n, pins.addr, pins.data_bus};

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   assign {cs_s, wr_s, rd_s, addr_s, data_s} = sync2_q;

   // ****************************************************************
   // mode select
   // ****************************************************************
   logic [2:0] mode_q;
   logic [2:0] mode_d;
   logic [2:0] msel1_q;
   logic [2:0] msel2_q;
   logic [1:0] strap_q;
   logic [1:0] strap_d;
   logic       is_strobed;
   logic       is_split;

   assign is_strobed = (mode_q == host_port_pkg::MODE_STROBED);
   assign is_split   = (mode_q == host_port_pkg::MODE_SPLIT);
   assign mode       = mode_q;

   // strap pins pass two flops before the one-time sample
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         msel1_q <= host_port_pkg::MODE_RESET;
         msel2_q <= host_port_pkg::MODE_RESET;
      end else begin
         msel1_q <= host_mode_select;
         msel2_q <= msel1_q;
      end
   end

   // ****************************************************************
   // access control
   // ****************************************************************
   dev_state_e                           state_q;
   dev_state_e                           state_d;
   logic [host_port_pkg::CNT_W-1:0]      busy_q;
   logic [host_port_pkg::CNT_W-1:0]      busy_d;
   logic [ADDR_W-1:0]                    addr_q;
   logic [ADDR_W-1:0]                    addr_d;
   logic [DATA_W-1:0]                    wdata_q;
   logic [DATA_W-1:0]                    wdata_d;
   logic [DATA_W-1:0]                    rdata_q;
   logic [DATA_W-1:0]                    rdata_d;
   logic                                 rd_pend_q;
   logic                                 rd_pend_d;
   logic                                 start_rd;
   logic                                 start_wr;
   logic                                 acc_end;
   logic                                 commit;

   always_comb begin
      start_rd = 1'b0;
      start_wr = 1'b0;
      acc_end  = cs_s;
      if (is_strobed) begin
         start_rd = !cs_s && wr_s;
         start_wr = !cs_s && !wr_s;
         acc_end  = cs_s;
      end else if (is_split) begin
         start_rd = !cs_s && !rd_s;
         start_wr = !cs_s && !wr_s && rd_s;
         acc_end  = cs_s || (rd_s && wr_s);
      end
   end

   assign commit = (state_q == S_WCAP) && acc_end;

   always_comb begin
      state_d   = state_q;
      addr_d    = addr_q;
      wdata_d   = wdata_q;
      rdata_d   = rdata_q;
      rd_pend_d = 1'b0;
      busy_d    = (busy_q != '0) ? busy_q - 1'b1 : busy_q;
      strap_d   = (strap_q == 2'h3) ? strap_q : strap_q + 2'h1;
      mode_d    = mode_q;
      if (strap_q == 2'(host_port_pkg::SYNC_STAGES)) begin
         mode_d = msel2_q;
      end
      unique case (state_q)
         S_IDLE: begin
            if (busy_q == '0 && start_rd) begin
               addr_d    = addr_s;
               rd_pend_d = 1'b1;
               state_d   = S_FETCH;
            end else if (busy_q == '0 && start_wr) begin
               addr_d  = addr_s;
               wdata_d = data_s;
               state_d = S_WCAP;
            end
         end
         S_FETCH: begin
            rdata_d = reg_rdata;
            state_d = S_HOLD;
         end
         S_HOLD: begin
            if (acc_end) begin
               state_d = S_IDLE;
            end
         end
         S_WCAP: begin
            if (acc_end) begin
               busy_d  = host_port_pkg::CNT_W'(host_port_pkg::WR_BUSY_CYC);
               state_d = S_IDLE;
               if (addr_q == host_port_pkg::MODE_REG_ADDR) begin
                  mode_d = wdata_q[host_port_pkg::MODE_LSB +: 3];
               end
            end else begin
               addr_d  = addr_s;
               wdata_d = data_s;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= S_IDLE;
         busy_q    <= '0;
         addr_q    <= '0;
         wdata_q   <= '0;
         rdata_q   <= '0;
         rd_pend_q <= 1'b0;
         strap_q   <= 2'h0;
         mode_q    <= host_port_pkg::MODE_RESET;
      end else begin
         state_q   <= state_d;
         busy_q    <= busy_d;
         addr_q    <= addr_d;
         wdata_q   <= wdata_d;
         rdata_q   <= rdata_d;
         rd_pend_q <= rd_pend_d;
         strap_q   <= strap_d;
         mode_q    <= mode_d;
      end
   end

   // ****************************************************************
   // register side
   // ****************************************************************
   assign reg_rd    = rd_pend_q;
   assign reg_wr    = commit;
   assign reg_addr  = addr_q;
   assign reg_wdata = wdata_q;

   // ****************************************************************
   // pin drivers
   // ****************************************************************
   logic ready;
   logic selected;

   assign ready              = (state_q == S_HOLD) || (state_q == S_WCAP);
   assign selected           = !cs_s && (is_strobed || is_split);
   assign pins.dev_ack_oe_n  = !selected;
   assign pins.dev_ack       = is_strobed ? !ready : ready;
   assign pins.dev_data_oe_n = !(selected && state_q == S_HOLD && !acc_end);
   assign pins.dev_data      = rdata_q;
endmodule : host_port_dev
`default_nettype wire

// *** src/host_port_host.sv ***
// host end of the parallel host port
`timescale 1ns/100ps
`default_nettype none
module host_port_host #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // pins
   host_port_if.host              pins,
   // bus style
   input  wire logic              split_mode,
   // request
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_ready,
   // answer
   output logic                   done,
   output logic [DATA_W-1:0]      rdata
);
   if (ADDR_W < 1 || DATA_W < 1) begin : g_bad
      $error("host_port_host: widths must be positive");
   end

   typedef enum logic [4:0] {
      H_IDLE  = 5'b00001,
      H_SETUP = 5'b00010,
      H_WAIT  = 5'b00100,
      H_END   = 5'b01000,
      H_GAP   = 5'b10000
   } host_state_e;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [DATA_W:0] sync1_q;
   logic [DATA_W:0] sync2_q;
   logic            ack_s;
   logic [DATA_W-1:0] data_s;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= {pins.transfer_ack, pins.data_bus};
         sync2_q <= sync1_q;
      end
   end

   assign {ack_s, data_s} = sync2_q;

   // ****************************************************************
   // access sequencer
   // ****************************************************************
   host_state_e                      state_q;
   host_state_e                      state_d;
   logic                             wr_q;
   logic                             wr_d;
   logic                             split_q;
   logic                             split_d;
   logic [ADDR_W-1:0]                addr_q;
   logic [ADDR_W-1:0]                addr_d;
   logic [DATA_W-1:0]                wdata_q;
   logic [DATA_W-1:0]                wdata_d;
   logic [DATA_W-1:0]                rdata_q;
   logic [DATA_W-1:0]                rdata_d;
   logic                             seen_q;
   logic                             seen_d;
   logic                             done_q;
   logic                             done_d;
   logic [host_port_pkg::CNT_W-1:0]  gap_q;
   logic [host_port_pkg::CNT_W-1:0]  gap_d;
   logic                             busy_lvl;

   // ready is low in strobed style, high in split style
   assign busy_lvl = split_q ? !ack_s : ack_s;

   always_comb begin
      state_d = state_q;
      wr_d    = wr_q;
      split_d = split_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      seen_d  = seen_q;
      done_d  = 1'b0;
      gap_d   = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
      unique case (state_q)
         H_IDLE: begin
            if (req_valid) begin
               wr_d    = req_write;
               split_d = split_mode;
               addr_d  = req_addr;
               wdata_d = req_wdata;
               seen_d  = 1'b0;
               state_d = H_SETUP;
            end
         end
         H_SETUP: begin
            state_d = H_WAIT;
         end
         H_WAIT: begin
            if (busy_lvl) begin
               seen_d = 1'b1;
            end else if (seen_q) begin
               rdata_d = data_s;
               state_d = H_END;
            end
         end
         H_END: begin
            done_d  = 1'b1;
            gap_d   = wr_q ? host_port_pkg::CNT_W'(host_port_pkg::WR_GAP_CYC)
                           : host_port_pkg::CNT_W'(host_port_pkg::RD_GAP_CYC);
            state_d = H_GAP;
         end
         H_GAP: begin
            if (gap_q <= host_port_pkg::CNT_W'(1)) begin
               state_d = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= H_IDLE;
         wr_q    <= 1'b0;
         split_q <= 1'b0;
         addr_q  <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         seen_q  <= 1'b0;
         done_q  <= 1'b0;
         gap_q   <= '0;
      end else begin
         state_q <= state_d;
         wr_q    <= wr_d;
         split_q <= split_d;
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         seen_q  <= seen_d;
         done_q  <= done_d;
         gap_q   <= gap_d;
      end
   end

   // ****************************************************************
   // pin drivers
   // ****************************************************************
   logic active;
   logic framing;

   assign active  = (state_q == H_SETUP) || (state_q == H_WAIT) || (state_q == H_END);
   assign framing = (state_q == H_WAIT);

   assign pins.chip_select_n  = !framing;
   assign pins.read_strobe_n  = !(framing && split_q && !wr_q);
   // strobed style: direction line, low for write, held through the end cycle
   assign pins.write_strobe_n = split_q ? !(framing && wr_q) : !(active && wr_q);
   assign pins.addr           = addr_q;
   assign pins.host_data      = wdata_q;
   assign pins.host_data_oe_n = !(active && wr_q);

   assign req_ready = (state_q == H_IDLE);
   assign done      = done_q;
   assign rdata     = rdata_q;
endmodule : host_port_host
`default_nettype wire

// *** tb/host_port_sva.sv ***
// concurrent checks on the pins between the two host port ends
`timescale 1ns/100ps
`default_nettype none
module host_port_sva #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic              clk_sys,
   input wire logic              rst_n,
   // host driven pins
   input wire logic              chip_select_n,
   input wire logic              write_strobe_n,
   input wire logic              read_strobe_n,
   input wire logic              host_data_oe_n,
   // device driven pins
   input wire logic [DATA_W-1:0] dev_data,
   input wire logic              dev_data_oe_n,
   input wire logic              dev_ack_oe_n,
   input wire logic              transfer_ack
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ****************
   // access sequences
   // ****************
   sequence strobed_rd_start;
      $fell(chip_select_n) && write_strobe_n && read_strobe_n;
   endsequence
   sequence split_rd_start;
      $fell(read_strobe_n) && !chip_select_n;
   endsequence
   sequence split_wait_then_ready;
      ##[1:6] !transfer_ack ##[1:30] transfer_ack;
   endsequence
   sequence sel_recent;
      !chip_select_n || !$past(chip_select_n) || !$past(chip_select_n, 2) || !$past(chip_select_n, 3);
   endsequence
   // ****************
   // assertions
   // ****************
   a_strobed_rd_ready: assert property (strobed_rd_start |-> ##[1:30] !transfer_ack)
      else $error("strobed read never became ready");
   a_strobed_rd_data: assert property (
      (!chip_select_n && write_strobe_n && read_strobe_n && $fell(transfer_ack)) |-> !dev_data_oe_n)
      else $error("strobed ready shown without read data");
   a_strobed_ready_stands: assert property (
      (!chip_select_n && write_strobe_n && read_strobe_n && !$past(transfer_ack) && !$past(chip_select_n))
      |-> !transfer_ack)
      else $error("strobed ready dropped while selected");
   a_split_rd_ready: assert property (split_rd_start |-> split_wait_then_ready)
      else $error("split read wait not followed by ready");
   a_split_rd_data: assert property (
      (!chip_select_n && !read_strobe_n && $rose(transfer_ack)) |-> !dev_data_oe_n)
      else $error("split ready shown without read data");
   a_data_only_selected: assert property (!dev_data_oe_n |-> sel_recent)
      else $error("data driven while not selected");
   a_no_bus_fight: assert property (!dev_data_oe_n |-> host_data_oe_n)
      else $error("both ends drive the data bus");
   a_ack_only_selected: assert property (!dev_ack_oe_n |-> sel_recent)
      else $error("ready driven while not selected");
   a_ack_released: assert property ($rose(chip_select_n) |-> ##[1:4] dev_ack_oe_n)
      else $error("ready not released after deselect");
   a_data_held: assert property ((!dev_data_oe_n && !$past(dev_data_oe_n)) |-> $stable(dev_data))
      else $error("read data changed while driven");
endmodule : host_port_sva
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench joining host and device ends of the host port
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ****************
   // signals
   // ****************
   logic        clk_sys          = 1'b0;
   logic        rst_n            = 1'b0;
   logic        split_mode       = 1'b0;
   logic        req_valid        = 1'b0;
   logic        req_write        = 1'b0;
   logic [6:0]  req_addr         = 7'h00;
   logic [7:0]  req_wdata        = 8'h00;
   logic [2:0]  host_mode_select = host_port_pkg::MODE_STROBED;
   logic        req_ready;
   logic        done;
   logic        reg_rd;
   logic        reg_wr;
   logic [7:0]  rdata;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [6:0]  reg_addr;
   logic [2:0]  mode;
   logic [7:0]  mem     [0:127];
   logic [7:0]  exp_mem [0:127];
   logic        kind_q  [$];
   logic [7:0]  rd_q    [$];
   logic [6:0]  ra_q    [$];
   logic [14:0] wr_q    [$];
   int          seed            = 37;
   int          error_cnt       = 0;
   int          samples_checked = 0;

   always #10 clk_sys = ~clk_sys;
   assign reg_rdata = mem[reg_addr];

   // ****************
   // instances
   // ****************
   host_port_if pins_if ();
   host_port_host host_port_host_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins_if), .split_mode(split_mode),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .done(done), .rdata(rdata)
   );
   host_port_dev host_port_dev_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins_if), .host_mode_select(host_mode_select),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .mode(mode)
   );
   host_port_sva host_port_sva_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .chip_select_n(pins_if.chip_select_n),
      .write_strobe_n(pins_if.write_strobe_n), .read_strobe_n(pins_if.read_strobe_n),
      .host_data_oe_n(pins_if.host_data_oe_n), .dev_data(pins_if.dev_data),
      .dev_data_oe_n(pins_if.dev_data_oe_n), .dev_ack_oe_n(pins_if.dev_ack_oe_n),
      .transfer_ack(pins_if.transfer_ack)
   );

   // ****************
   // tasks
   // ****************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
      logic ok;
      int   n;
      ok = 1'b0;
      n = 0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      while (!ok) begin
         @(negedge clk_sys);
         ok = (req_ready === 1'b1);
         @(posedge clk_sys);
         n++;
         if (n > 400) begin
            error_cnt++;
            end_of_test();
         end
      end
      req_valid <= 1'b0;
      kind_q.push_back(w);
      if (w) begin
         exp_mem[a] = d;
         if (a != host_port_pkg::MODE_REG_ADDR) wr_q.push_back({a, d});
      end else begin
         rd_q.push_back(exp_mem[a]);
         ra_q.push_back(a);
      end
   endtask : access

   task automatic wait_idle();
      int n;
      n = 0;
      while (kind_q.size() != 0 || wr_q.size() != 0) begin
         @(posedge clk_sys);
         n++;
         if (n > 400) begin
            error_cnt++;
            end_of_test();
         end
      end
      repeat (host_port_pkg::WR_BUSY_CYC + 2) @(posedge clk_sys);
   endtask : wait_idle

   // write then read back to back, then read after read
   task automatic run_ops();
      logic [6:0] a;
      logic [7:0] d;
      for (int k = 0; k < 8; k++) begin
         a = 7'($random(seed)) & 7'h3f;
         d = 8'($random(seed));
         access(1'b1, a, d);
         access(1'b0, a, 8'h00);
         access(1'b0, 7'($random(seed)) & 7'h3f, 8'h00);
      end
   endtask : run_ops

   // ****************
   // result watcher
   // ****************
   always @(posedge clk_sys) begin
      if (done === 1'b1) begin
         if (kind_q.size() == 0) check(16'h0001, 16'h0000);
         else if (kind_q.pop_front() == 1'b0) check(rdata, rd_q.pop_front());
      end
      if (reg_wr === 1'b1 && reg_addr !== host_port_pkg::MODE_REG_ADDR) begin
         if (wr_q.size() == 0) check(16'h0001, 16'h0000);
         else check({reg_addr, reg_wdata}, wr_q.pop_front());
      end
      if (reg_rd === 1'b1) begin
         if (ra_q.size() == 0) check(16'h0001, 16'h0000);
         else check(reg_addr, ra_q.pop_front());
      end
      if (rst_n !== 1'b1) begin
         for (int i = 0; i < 128; i++) mem[i] <= 8'(i) ^ 8'ha5;
      end else if (reg_wr === 1'b1) begin
         mem[reg_addr] <= reg_wdata;
      end
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      for (int i = 0; i < 128; i++) begin
         exp_mem[i] = 8'(i) ^ 8'ha5;
      end
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(mode, host_port_pkg::MODE_STROBED);
      run_ops();
      access(1'b1, host_port_pkg::MODE_REG_ADDR, 8'(host_port_pkg::MODE_SPLIT));
      wait_idle();
      check(mode, host_port_pkg::MODE_SPLIT);
      split_mode <= 1'b1;
      run_ops();
      wait_idle();
      check(16'(kind_q.size() + rd_q.size() + ra_q.size() + wr_q.size()), 16'h0000);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
